// [common/scvs_pkg.sv]
// Purpose: Shared constants and types for the card supply sequencer.
// Assumes: 8-bit registers on a 16-bit register address, 40 MHz clock.
// Notes:   Every offset, field position and reset value lives here.
package scvs_pkg;

	// Register addresses.
	localparam logic [15:0] ADDR_IRQ_EN = 16'hfe02;
	localparam logic [15:0] ADDR_CTRL   = 16'hfe03;

	// Reset values.
	localparam logic [7:0] IRQ_EN_RESET = 8'h00;
	localparam logic [7:0] CTRL_RESET   = 8'h00;

	// Supply control and status field positions.
	localparam int CTRL_SEL_HI = 7;
	localparam int CTRL_SEL_LO = 6;
	localparam int CTRL_MODE   = 5;
	localparam int CTRL_RDY    = 4;
	localparam int CTRL_STABLE = 3;
	localparam int CTRL_PDN    = 0;

	// Interrupt enable field positions.
	localparam int IE_WAIT_TIMEOUT = 7;
	localparam int IE_CARD_EVENT   = 6;
	localparam int IE_SUPPLY_TIMER = 5;
	localparam int IE_RX_AVAILABLE = 4;
	localparam int IE_TX_EVENT     = 3;
	localparam int IE_TX_SENT      = 2;
	localparam int IE_TX_ERROR     = 1;
	localparam int IE_RX_ERROR     = 0;

	// Supply select encodings.
	localparam logic [1:0] SEL_OFF    = 2'h0;
	localparam logic [1:0] SEL_1V8    = 2'h1;
	localparam logic [1:0] SEL_3V0    = 2'h2;
	localparam logic [1:0] SEL_5V0    = 2'h3;

	// Spacing between successive card line changes.
	localparam int CLK_PERIOD_NS    = 25;
	localparam int LINE_STEP_NS     = 100;
	localparam int LINE_STEP_CYCLES =
		(LINE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT_STABLE,
		ST_ACTIVE,
		ST_DEACT,
		ST_SUPPLY_OFF,
		ST_LOCKED
	} scvs_state_type;

endpackage : scvs_pkg

// [common/scvs_line_if.sv]
// Purpose: Carries card line requests and states between the sequencer
//          and the line stepper.
// Assumes: Both ends run on the same clock.
// Notes:   Line states are registered in the stepper.
`timescale 1ns/100ps
interface scvs_line_if;
	logic go_up;
	logic go_down;
	logic lines_up;
	logic lines_down;
	logic card_rst_n;
	logic card_clk_en;
	logic card_io_en;

	modport ctrl (
		output go_up,
		output go_down,
		input  lines_up,
		input  lines_down,
		input  card_rst_n,
		input  card_clk_en,
		input  card_io_en
	);

	modport seq (
		input  go_up,
		input  go_down,
		output lines_up,
		output lines_down,
		output card_rst_n,
		output card_clk_en,
		output card_io_en
	);
endinterface : scvs_line_if

// [logic/scvs_line_stepper.sv]
// Purpose: Brings the card I/O, clock and reset lines up and down in order.
// Assumes: Requests come from logic on the same clock.
// Notes:   Down order is reset, then clock, then I/O; up is the reverse.
`timescale 1ns/100ps
module scvs_line_stepper
	import scvs_pkg::*;
#(
	parameter int STEP_CYCLES = LINE_STEP_CYCLES
) (
	input  wire logic i_clk,
	input  wire logic i_resetn,
	scvs_line_if.seq  line
);

	initial begin
		if (STEP_CYCLES < 1 || STEP_CYCLES > 255) begin
			$error("STEP_CYCLES must lie in 1..255");
		end
	end

	logic [1:0] stage_q;
	logic [1:0] stage_d;
	logic [7:0] wait_q;
	logic [7:0] wait_d;
	logic       step_due;
	logic       climb;
	logic       fall;

	assign step_due = (wait_q == 8'h00);
	assign fall     = line.go_down && (stage_q != 2'h0);
	assign climb    = line.go_up && !line.go_down && (stage_q != 2'h3);

	always_comb begin
		stage_d = stage_q;
		wait_d  = 8'h00;
		if (fall || climb) begin
			wait_d = step_due ? 8'(STEP_CYCLES - 1) : wait_q - 8'h01;
			if (step_due && fall) begin
				stage_d = stage_q - 2'h1;
			end else if (step_due) begin
				stage_d = stage_q + 2'h1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			stage_q          <= 2'h0;
			wait_q           <= 8'h00;
			line.lines_up    <= 1'b0;
			line.lines_down  <= 1'b1;
			line.card_rst_n  <= 1'b0;
			line.card_clk_en <= 1'b0;
			line.card_io_en  <= 1'b0;
		end else begin
			stage_q          <= stage_d;
			wait_q           <= wait_d;
			line.lines_up    <= (stage_d == 2'h3);
			line.lines_down  <= (stage_d == 2'h0);
			line.card_rst_n  <= (stage_d == 2'h3);
			line.card_clk_en <= (stage_d >= 2'h2);
			line.card_io_en  <= (stage_d >= 2'h1);
		end
	end

endmodule : scvs_line_stepper

// [logic/scvs_sequencer.sv]
// Purpose: Card slot supply activation and deactivation sequencer with the
//          per-source card interrupt enables.
// Assumes: Supply-stable and host fault arrive from pins; flags, card
//          events, mode and timer expiry come from logic on this clock.
// Notes:   Register reads answer in the cycle after the read strobe.
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps

// How it works
// - Enable register holds one enable per source, bit 7 down to bit 0.
// - In synchronous mode bit 7 enables the receive length maximum interrupt.
// - A source interrupts only while enabled; its flag still sets regardless.
// - Writing a non-zero supply select starts activation at 1.8, 3.0 or 5 V.
// - A card event or supply-stable falling low starts deactivation.
// - Except on a host-fault emergency, deactivation shuts reset, clock and I/O first, then the supply.
// - With fault mode 0 a host fault in the wait-stable or active state drives both supply commands high.
// - Fault mode 0 gives an emergency slot deactivation on host fault; fault mode 1 ignores it.
// - With ready-start set, activation proceeds once supply is stable.
// - With ready-start clear, activation proceeds when the timer expires; an unstable supply then starts deactivation.
// - Control bit 3 is read only and shows supply stability.
// - Control bit 0 selects power-down when 1, normal operation when 0.
// - The supply control register resets to zero, supply off.
module scvs_sequencer
	import scvs_pkg::*;
#(
	parameter int STEP_CYCLES = LINE_STEP_CYCLES
) (
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	input  wire logic [15:0] i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [7:0]  o_rdata,
	input  wire logic        i_supply_stable,
	input  wire logic        i_host_fault,
	input  wire logic        i_card_event,
	input  wire logic        i_supply_timer_expired,
	input  wire logic        i_sync_mode,
	input  wire logic [7:0]  i_irq_flags,
	input  wire logic        i_rx_length_max_flag,
	output logic             o_card_irq,
	output logic             o_supply_timer_start,
	output logic             o_supply_on,
	output logic      [1:0]  o_supply_level,
	output logic             o_supply_cmd_low_volt_n,
	output logic             o_supply_cmd_high_volt_n,
	output logic             o_card_rst_n,
	output logic             o_card_clk_en,
	output logic             o_card_io_en,
	output logic             o_slot_power_down,
	output logic             o_sequencer_busy
);

	initial begin
		if (STEP_CYCLES < 1 || STEP_CYCLES > 255) begin
			$error("STEP_CYCLES must lie in 1..255");
		end
	end

	// Maps a supply select code to the two active-low companion commands.
	// The low-voltage command covers 1.8 V and 3.0 V, the high one 5 V.
	function automatic logic [1:0] supply_cmd(input logic [1:0] sel);
		logic [1:0] cmd;
		cmd = 2'h3;
		if (sel == SEL_5V0) begin
			cmd = 2'h2;
		end else if (sel == SEL_1V8 || sel == SEL_3V0) begin
			cmd = 2'h1;
		end
		return cmd;
	endfunction : supply_cmd

	// True in the states in which the card supply is brought up and held, before any shutdown starts.
	function automatic logic in_supply_state(input scvs_state_type st);
		return (st == ST_WAIT_STABLE) || (st == ST_ACTIVE);
	endfunction : in_supply_state

	// ------------------------------------------------------------------
	// Pin synchronisers.
	// ------------------------------------------------------------------
	logic stable_meta_q;
	logic stable_sync_q;
	logic stable_prev_q;
	logic fault_meta_q;
	logic fault_sync_q;

	// Only the second flop of each pair is read; the stable copy is also
	// delayed once more to find its falling edge.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			stable_meta_q <= 1'b0;
			stable_sync_q <= 1'b0;
			stable_prev_q <= 1'b0;
			fault_meta_q  <= 1'b0;
			fault_sync_q  <= 1'b0;
		end else begin
			stable_meta_q <= i_supply_stable;
			stable_sync_q <= stable_meta_q;
			stable_prev_q <= stable_sync_q;
			fault_meta_q  <= i_host_fault;
			fault_sync_q  <= fault_meta_q;
		end
	end

	// ------------------------------------------------------------------
	// Register decode.
	// ------------------------------------------------------------------
	logic       sel_ie;
	logic       sel_ctrl;
	logic       wr_ie;
	logic       wr_ctrl;
	logic [7:0] ctrl_view;
	logic [7:0] rd_value;

	logic [7:0] irq_en_q;
	logic [1:0] supply_select_q;
	logic       host_fault_mode_q;
	logic       ready_start_q;
	logic       slot_power_down_q;

	assign sel_ie   = (i_addr == ADDR_IRQ_EN);
	assign sel_ctrl = (i_addr == ADDR_CTRL);
	assign wr_ie    = i_wr && sel_ie;
	assign wr_ctrl  = i_wr && sel_ctrl;

	// Bits 2:1 are unused and read as zero; bit 3 is live status.
	assign ctrl_view = {supply_select_q, host_fault_mode_q, ready_start_q,
		stable_sync_q, 2'h0, slot_power_down_q};

	assign rd_value = !i_rd ? 8'h00 :
		sel_ie ? irq_en_q :
		sel_ctrl ? ctrl_view : 8'h00;

	// Both select bits are taken from the one write that carries them.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			irq_en_q          <= IRQ_EN_RESET;
			supply_select_q   <= CTRL_RESET[CTRL_SEL_HI:CTRL_SEL_LO];
			host_fault_mode_q <= CTRL_RESET[CTRL_MODE];
			ready_start_q     <= CTRL_RESET[CTRL_RDY];
			slot_power_down_q <= CTRL_RESET[CTRL_PDN];
			o_rdata           <= 8'h00;
		end else begin
			o_rdata <= rd_value;
			if (wr_ie) begin
				irq_en_q <= i_wdata;
			end
			if (wr_ctrl) begin
				supply_select_q   <= i_wdata[CTRL_SEL_HI:CTRL_SEL_LO];
				host_fault_mode_q <= i_wdata[CTRL_MODE];
				ready_start_q     <= i_wdata[CTRL_RDY];
				slot_power_down_q <= i_wdata[CTRL_PDN];
			end
		end
	end

	// ------------------------------------------------------------------
	// Interrupt gating.
	// ------------------------------------------------------------------
	logic [7:0] irq_sources;
	logic       irq_d;

	// Bit 7 watches the receive length flag in synchronous mode.
	assign irq_sources = {i_sync_mode ? i_rx_length_max_flag
		: i_irq_flags[IE_WAIT_TIMEOUT], i_irq_flags[6:0]};

	// Flags stay set outside; only the request is masked.
	assign irq_d = |(irq_sources & irq_en_q);

	// ------------------------------------------------------------------
	// Supply sequencing.
	// ------------------------------------------------------------------
	// The stepper owns the card lines; the sequencer only asks for them to
	// come up or go down and waits for the all-down report.
	scvs_line_if line_bus ();

	scvs_line_stepper #(
		.STEP_CYCLES (STEP_CYCLES)
	) u_lines (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.line     (line_bus.seq)
	);

	scvs_state_type state_q;
	scvs_state_type state_d;
	logic           emerg_q;
	logic           emerg_d;
	logic           lock_q;
	logic           lock_d;
	logic           stable_fell;
	logic           fault_hit;
	logic           card_hit;
	logic           powered;
	logic           supplying_d;
	logic [1:0]     cmd_d;
	logic           timer_start_d;
	logic [1:0]     level_q;
	logic [1:0]     level_d;
	logic [1:0]     level_out_d;
	logic           busy_d;

	assign powered     = in_supply_state(state_q);
	assign stable_fell = stable_prev_q && !stable_sync_q;
	assign card_hit    = powered && (i_card_event || stable_fell);
	assign fault_hit   = powered && fault_sync_q &&
		!host_fault_mode_q;

	// Card events, a lost supply, a host fault and an unstable supply at
	// timer expiry lock the slot until firmware writes the select to zero;
	// a plain select of zero shuts down and returns straight to idle.
	always_comb begin
		state_d       = state_q;
		emerg_d       = emerg_q;
		lock_d        = lock_q;
		timer_start_d = 1'b0;
		case (state_q)
			ST_IDLE: begin
				emerg_d = 1'b0;
				lock_d  = 1'b0;
				if (supply_select_q != SEL_OFF) begin
					state_d       = ST_WAIT_STABLE;
					timer_start_d = 1'b1;
				end
			end
			ST_WAIT_STABLE: begin
				if (fault_hit) begin
					state_d = ST_DEACT;
					emerg_d = 1'b1;
					lock_d  = 1'b1;
				end else if (card_hit) begin
					state_d = ST_DEACT;
					lock_d  = 1'b1;
				end else if (supply_select_q == SEL_OFF) begin
					state_d = ST_DEACT;
				end else if (ready_start_q && stable_sync_q) begin
					state_d = ST_ACTIVE;
				end else if (i_supply_timer_expired && !stable_sync_q) begin
					state_d = ST_DEACT;
					lock_d  = 1'b1;
				end else if (i_supply_timer_expired) begin
					state_d = ST_ACTIVE;
				end
			end
			ST_ACTIVE: begin
				if (fault_hit) begin
					state_d = ST_DEACT;
					emerg_d = 1'b1;
					lock_d  = 1'b1;
				end else if (card_hit) begin
					state_d = ST_DEACT;
					lock_d  = 1'b1;
				end else if (supply_select_q == SEL_OFF) begin
					state_d = ST_DEACT;
				end
			end
			ST_DEACT: begin
				if (line_bus.lines_down) begin
					state_d = ST_SUPPLY_OFF;
				end
			end
			ST_SUPPLY_OFF: begin
				state_d = lock_q ? ST_LOCKED : ST_IDLE;
			end
			ST_LOCKED: begin
				if (supply_select_q == SEL_OFF) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	assign line_bus.go_up   = (state_q == ST_ACTIVE);
	assign line_bus.go_down = (state_q != ST_ACTIVE);

	assign supplying_d = in_supply_state(state_d) || (state_d == ST_DEACT);

	// The level is captured when activation starts and held through the
	// shutdown, so clearing the select cannot cut the supply early.
	assign level_d     = (state_q == ST_IDLE) ? supply_select_q
		: level_q;
	assign level_out_d = supplying_d ? level_d : SEL_OFF;
	assign busy_d      = (state_d != ST_IDLE) && (state_d != ST_LOCKED);

	// An emergency or a finished shutdown forces both commands inactive.
	assign cmd_d = (fault_hit || emerg_d || !supplying_d) ? 2'h3
		: supply_cmd(level_d);

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_q <= ST_IDLE;
			emerg_q <= 1'b0;
			lock_q  <= 1'b0;
			level_q <= SEL_OFF;
		end else begin
			state_q <= state_d;
			emerg_q <= emerg_d;
			lock_q  <= lock_d;
			level_q <= level_d;
		end
	end

	// Every top-level output except the card lines and read data is taken from a register here.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_card_irq               <= 1'b0;
			o_supply_timer_start     <= 1'b0;
			o_supply_on              <= 1'b0;
			o_supply_level           <= SEL_OFF;
			o_supply_cmd_low_volt_n  <= 1'b1;
			o_supply_cmd_high_volt_n <= 1'b1;
			o_slot_power_down        <= 1'b0;
			o_sequencer_busy         <= 1'b0;
		end else begin
			o_card_irq               <= irq_d;
			o_supply_timer_start     <= timer_start_d;
			o_supply_on              <= supplying_d;
			o_supply_level           <= level_out_d;
			o_supply_cmd_low_volt_n  <= cmd_d[1];
			o_supply_cmd_high_volt_n <= cmd_d[0];
			o_slot_power_down        <= slot_power_down_q;
			o_sequencer_busy         <= busy_d;
		end
	end

	// Card lines come straight from the stepper's flip-flops.
	assign o_card_rst_n  = line_bus.card_rst_n;
	assign o_card_clk_en = line_bus.card_clk_en;
	assign o_card_io_en  = line_bus.card_io_en;

endmodule : scvs_sequencer

// [verification/scvs_sequencer_chk.sv]
// Purpose: Port checks for the card supply sequencer.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Register shadows are rebuilt from bus writes.
`timescale 1ns/100ps
module scvs_sequencer_chk
	import scvs_pkg::*;
#(
	parameter int STEP_CYCLES = LINE_STEP_CYCLES
) (
	input wire logic        i_clk,
	input wire logic        i_resetn,
	input wire logic [15:0] i_addr,
	input wire logic [7:0]  i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [7:0]  o_rdata,
	input wire logic        i_supply_stable,
	input wire logic        i_host_fault,
	input wire logic        i_card_event,
	input wire logic        i_supply_timer_expired,
	input wire logic        i_sync_mode,
	input wire logic [7:0]  i_irq_flags,
	input wire logic        i_rx_length_max_flag,
	input wire logic        o_card_irq,
	input wire logic        o_supply_timer_start,
	input wire logic        o_supply_on,
	input wire logic [1:0]  o_supply_level,
	input wire logic        o_supply_cmd_low_volt_n,
	input wire logic        o_supply_cmd_high_volt_n,
	input wire logic        o_card_rst_n,
	input wire logic        o_card_clk_en,
	input wire logic        o_card_io_en,
	input wire logic        o_slot_power_down,
	input wire logic        o_sequencer_busy
);
	localparam int FLT_MAX = 6;
	localparam int OFF_MAX = 40;
	logic [7:0] en_q;
	logic [7:0] ctl_q;
	logic [7:0] src;
	logic       exp_irq;
	logic       wr_en;
	logic       wr_ctl;
	logic       sel_5v;
	assign wr_en = i_wr && i_addr == ADDR_IRQ_EN;
	assign wr_ctl = i_wr && i_addr == ADDR_CTRL;
	assign sel_5v = ctl_q[7:6] == SEL_5V0;
	assign src = {i_sync_mode ? i_rx_length_max_flag : i_irq_flags[7],
		i_irq_flags[6:0]};
	assign exp_irq = |(src & en_q);
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			en_q  <= IRQ_EN_RESET;
			ctl_q <= CTRL_RESET;
		end else if (wr_en) begin
			en_q <= i_wdata;
		end else if (wr_ctl) begin
			ctl_q <= i_wdata & 8'hf1;
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	sequence s_ctl_read;
		i_rd && i_addr == ADDR_CTRL;
	endsequence
	sequence s_lines_down;
		!o_card_rst_n && !o_card_clk_en && !o_card_io_en;
	endsequence
	property p_irq_gate;
		exp_irq == $past(exp_irq) && exp_irq == $past(exp_irq, 2)
			|-> o_card_irq == exp_irq;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("card irq does not follow enabled sources");
	property p_rd_en;
		$past(i_rd && i_addr == ADDR_IRQ_EN) |-> o_rdata == $past(en_q);
	endproperty
	a_rd_en: assert property (p_rd_en)
		else $error("enable readback wrong");
	property p_rd_ctl;
		s_ctl_read |=> (o_rdata & 8'hf7) == $past(ctl_q);
	endproperty
	a_rd_ctl: assert property (p_rd_ctl)
		else $error("control readback wrong");
	property p_start;
		o_supply_timer_start |->
			$past(wr_ctl && i_wdata[7:6] != SEL_OFF, 2);
	endproperty
	a_start: assert property (p_start)
		else $error("activation started without a select write");
	property p_level;
		o_supply_timer_start |-> o_supply_on &&
			o_supply_level == ctl_q[7:6] &&
			o_supply_cmd_high_volt_n == !sel_5v &&
			o_supply_cmd_low_volt_n == sel_5v;
	endproperty
	a_level: assert property (p_level)
		else $error("supply level or command wrong at activation");
	property p_up_order;
		$rose(o_card_rst_n) |-> o_card_clk_en && o_card_io_en;
	endproperty
	a_up_order: assert property (p_up_order)
		else $error("card reset released before clock and io");
	property p_off_last;
		$fell(o_supply_on) |-> s_lines_down;
	endproperty
	a_off_last: assert property (p_off_last)
		else $error("supply removed before card lines were down");
	property p_cmd_hold;
		$rose(o_supply_cmd_low_volt_n && o_supply_cmd_high_volt_n) &&
			!(i_host_fault && !ctl_q[CTRL_MODE]) |-> s_lines_down;
	endproperty
	a_cmd_hold: assert property (p_cmd_hold)
		else $error("supply command dropped before card lines were down");
	property p_io_last;
		$fell(o_card_io_en) |-> !o_card_rst_n && !o_card_clk_en;
	endproperty
	a_io_last: assert property (p_io_last)
		else $error("io dropped before reset and clock");
	property p_fault;
		$rose(i_host_fault) && !ctl_q[CTRL_MODE] |-> ##[1:FLT_MAX]
			(o_supply_cmd_low_volt_n && o_supply_cmd_high_volt_n);
	endproperty
	a_fault: assert property (p_fault)
		else $error("host fault did not raise both supply commands");
	property p_event;
		i_card_event && o_supply_on |-> ##[1:OFF_MAX] !o_supply_on;
	endproperty
	a_event: assert property (p_event)
		else $error("card event did not remove the supply");
	property p_pdn;
		ctl_q[CTRL_PDN] == $past(ctl_q[CTRL_PDN])
			|-> o_slot_power_down == ctl_q[CTRL_PDN];
	endproperty
	a_pdn: assert property (p_pdn)
		else $error("power-down output differs from control bit");
endmodule : scvs_sequencer_chk

bind scvs_sequencer scvs_sequencer_chk #(.STEP_CYCLES(STEP_CYCLES)) chk (.*);

// [verification/scvs_supply_model.sv]
// Purpose: Companion supply that reports a stable card supply.
// Assumes: Supply is asked for while either command output is low.
// Notes:   Stable follows a delay in cycles; a drop forces it low.
`timescale 1ns/100ps
module scvs_supply_model (
	input  wire logic       i_clk,
	input  wire logic       i_supply_on,
	input  wire logic       i_cmd_low_volt_n,
	input  wire logic       i_cmd_high_volt_n,
	input  wire logic [7:0] i_delay,
	input  wire logic       i_drop,
	output logic            o_supply_stable
);
	logic [7:0] count_q;
	logic       want;
	assign want = i_supply_on && !i_drop &&
		!(i_cmd_low_volt_n && i_cmd_high_volt_n);
	initial begin
		count_q = 8'h00;
		o_supply_stable = 1'b0;
	end
	always @(posedge i_clk) begin
		if (!want) begin
			count_q <= 8'h00;
			o_supply_stable <= 1'b0;
		end else if (count_q < i_delay) begin
			count_q <= count_q + 8'h01;
		end else begin
			o_supply_stable <= 1'b1;
		end
	end
endmodule : scvs_supply_model

// [verification/test_scvs_sequencer.sv]
// Purpose: Self-checking bench for the card supply sequencer.
// Assumes: 40 MHz clock; short line steps for a quick run.
// Notes:   Read results are queued by the driver and checked by a monitor.
`timescale 1ns/100ps
module test_scvs_sequencer
	import scvs_pkg::*;
;
	logic i_clk, i_resetn, i_wr, i_rd, i_supply_stable, i_host_fault;
	logic i_card_event, i_supply_timer_expired, i_sync_mode;
	logic i_rx_length_max_flag, o_card_irq, o_supply_timer_start;
	logic o_supply_on, o_supply_cmd_low_volt_n, o_supply_cmd_high_volt_n;
	logic o_card_rst_n, o_card_clk_en, o_card_io_en, o_slot_power_down;
	logic o_sequencer_busy, rd_seen, drop;
	logic [15:0] i_addr;
	logic [7:0]  i_wdata, i_irq_flags, o_rdata, dly, v, c, src;
	logic [1:0]  o_supply_level;
	logic [7:0]  exp_q[$];
	int          miscompares, comparisons, cycles;

	scvs_sequencer #(.STEP_CYCLES(2)) uut (.*);
	scvs_supply_model model (
		.i_clk             (i_clk),
		.i_supply_on       (o_supply_on),
		.i_cmd_low_volt_n  (o_supply_cmd_low_volt_n),
		.i_cmd_high_volt_n (o_supply_cmd_high_volt_n),
		.i_delay           (dly),
		.i_drop            (drop),
		.o_supply_stable   (i_supply_stable)
	);

	task check(input logic [7:0] seen, input logic [7:0] want);
		comparisons++;
		if (seen !== want) begin
			miscompares++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask : check
	task give_verdict;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr
	task rd(input logic [15:0] a, input logic [7:0] want);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		exp_q.push_back(want);
		@(posedge i_clk);
		i_rd <= 1'b0;
	endtask : rd
	task wait_on(input logic lvl);
		for (int n = 0; n < 80 && o_supply_on !== lvl; n++)
			@(posedge i_clk);
		check(o_supply_on, lvl);
	endtask : wait_on
	task act(input logic [7:0] d);
		wr(ADDR_CTRL, d);
		wait_on(1'b1);
		for (int n = 0; n < 80 && o_card_rst_n !== 1'b1; n++)
			@(posedge i_clk);
		check(o_card_rst_n, 1'b1);
	endtask : act
	task pulse_event;
		i_card_event <= 1'b1;
		@(posedge i_clk);
		i_card_event <= 1'b0;
	endtask : pulse_event

	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		rd_seen <= i_rd;
		if (rd_seen)
			check(o_rdata, exp_q.pop_front());
		cycles++;
		if (cycles == 6000) begin
			miscompares++;
			give_verdict();
		end
	end

	initial begin
		{i_resetn, i_wr, i_rd, i_host_fault, i_card_event, drop} = 6'h00;
		{i_supply_timer_expired, i_sync_mode, i_rx_length_max_flag} = 3'h0;
		{i_addr, i_wdata, i_irq_flags} = 32'h0;
		{miscompares, comparisons, cycles, rd_seen} = 0;
		dly = 8'h05;
		v = 8'($urandom(89));
		repeat (20) @(posedge i_clk);
		i_resetn <= 1'b1;
		rd(ADDR_CTRL, CTRL_RESET);
		rd(ADDR_IRQ_EN, IRQ_EN_RESET);
		rd(16'hfe04, 8'h00);
		check({o_supply_cmd_low_volt_n, o_supply_on}, 8'h02);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			v = 8'($urandom);
			wr(ADDR_IRQ_EN, v);
			rd(ADDR_IRQ_EN, v);
			i_irq_flags <= 8'($urandom);
			i_sync_mode <= i[0];
			i_rx_length_max_flag <= 1'($urandom);
			repeat (3) @(posedge i_clk);
			src = {i_sync_mode ? i_rx_length_max_flag : i_irq_flags[7],
				i_irq_flags[6:0]};
			check(o_card_irq, |(src & v));
		end
		$display("test enables done");
		for (int s = 1; s < 4; s++) begin
			c = {s[1:0], 6'h10};
			act(c);
			check(o_supply_level, s[1:0]);
			check(o_sequencer_busy, 1'b1);
			check({o_supply_cmd_high_volt_n, o_supply_cmd_low_volt_n},
				{s != 3, s == 3});
			rd(ADDR_CTRL, c | 8'h08);
			wr(ADDR_CTRL, 8'h00);
			wait_on(1'b0);
			check({o_card_rst_n, o_card_clk_en, o_card_io_en}, 8'h00);
		end
		$display("test activation done");
		act(8'h90);
		pulse_event();
		wait_on(1'b0);
		check({o_supply_cmd_low_volt_n, o_supply_cmd_high_volt_n}, 8'h03);
		wr(ADDR_CTRL, 8'h90);
		repeat (8) @(posedge i_clk);
		check(o_supply_on, 1'b0);
		check(o_sequencer_busy, 1'b0);
		wr(ADDR_CTRL, 8'h00);
		act(8'h90);
		drop <= 1'b1;
		wait_on(1'b0);
		drop <= 1'b0;
		wr(ADDR_CTRL, 8'h00);
		$display("test card event done");
		act(8'hd0);
		i_host_fault <= 1'b1;
		repeat (6) @(posedge i_clk);
		check({o_supply_cmd_low_volt_n, o_supply_cmd_high_volt_n}, 8'h03);
		wait_on(1'b0);
		i_host_fault <= 1'b0;
		wr(ADDR_CTRL, 8'h00);
		act(8'h70);
		i_host_fault <= 1'b1;
		repeat (6) @(posedge i_clk);
		check(o_supply_cmd_low_volt_n, 1'b0);
		wr(ADDR_CTRL, 8'h20);
		wait_on(1'b0);
		i_host_fault <= 1'b0;
		wr(ADDR_CTRL, 8'h00);
		$display("test host fault done");
		dly <= 8'hff;
		wr(ADDR_CTRL, 8'h40);
		wait_on(1'b1);
		i_supply_timer_expired <= 1'b1;
		@(posedge i_clk);
		i_supply_timer_expired <= 1'b0;
		wait_on(1'b0);
		wr(ADDR_CTRL, 8'h00);
		dly <= 8'h05;
		$display("test timer done");
		wr(ADDR_CTRL, 8'h09);
		repeat (3) @(posedge i_clk);
		check(o_slot_power_down, 1'b1);
		rd(ADDR_CTRL, 8'h01);
		wr(16'hfe04, 8'hff);
		rd(ADDR_IRQ_EN, v);
		wr(ADDR_CTRL, 8'h00);
		repeat (3) @(posedge i_clk);
		check(o_slot_power_down, 1'b0);
		$display("test power down done");
		give_verdict();
	end
endmodule : test_scvs_sequencer
